//--- cipp_pkg.sv
package cipp_pkg;
   localparam int NCH = 4;
   localparam int AVG_MAX = 80;
   localparam int IMG_WORDS = 8;
   localparam logic [7:0] AVG_RST = 8'h01;
   localparam logic [7:0] AVG_LO = 8'h01;
   localparam logic [7:0] AVG_HI = 8'h50;
   localparam logic [7:0] SUB_LO = 8'h01;
   localparam logic [7:0] SUB_HI = 8'h04;
   localparam logic [7:0] IDX_HI = 8'h24;
   localparam logic [7:0] IDX_OFFSET = 8'h00;
   localparam logic [7:0] IDX_MAXCNT = 8'h01;
   localparam logic [7:0] IDX_AVG = 8'h02;
   localparam logic [7:0] IDX_ENABLE = 8'h03;
   localparam logic [7:0] LEN_BYTE = 8'h01;
   localparam logic [7:0] LEN_WORD = 8'h02;
   localparam logic [16:0] FULL_SGN = 17'h07D00;
   localparam logic [16:0] FULL_UNS = 17'h0FA00;
   localparam logic signed [18:0] CLAMP_SGN_LO = 19'h7FD01;
   localparam logic signed [18:0] CLAMP_SGN_HI = 19'h07FFF;
   localparam logic signed [18:0] CLAMP_UNS_HI = 19'h0FFFF;
   localparam int ST_GS = 0;
   localparam int ST_PDM = 1;
   localparam int ST_OCE = 3;
   localparam int ST_BWE = 6;
   localparam int ST_ICE = 7;
   localparam logic [5:0] DIV_STEPS = 6'h28;
   localparam logic [15:0] IMG_FIRST = 16'hB150;
   localparam logic [15:0] IMG_LAST = 16'hC14F;
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_BASE = 8'h04;
   localparam logic [7:0] A_CMD = 8'h08;
   localparam logic [7:0] A_DATA = 8'h0C;
   localparam logic [7:0] A_STAT = 8'h10;
   localparam logic [7:0] A_ISTAT = 8'h14;
   localparam logic [7:0] A_IMASK = 8'h18;
   localparam logic [7:0] A_IMG = 8'h20;
   localparam int IRQ_RTP = 0;
   localparam int IRQ_SCAN = 1;
   localparam int IRQ_GS = 2;
   localparam int IRQ_W = 3;
   localparam int CLK_HZ = 100_000_000;
   localparam int BLINK_MS = 250;
   localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
endpackage : cipp_pkg

//--- cipp_if.sv
`timescale 1ns/1ps
interface cipp_if;
   logic rtp_valid;
   logic [7:0] rtp_len;
   logic [7:0] rtp_idx_lo;
   logic [7:0] rtp_idx_hi;
   logic [7:0] rtp_sub;
   logic [15:0] rtp_data;
   logic rtp_done;
   logic rtp_err;
   logic img_rd;
   logic [2:0] img_addr;
   logic img_rvalid;
   logic [15:0] img_rdata;
   modport dev (input rtp_valid, rtp_len, rtp_idx_lo, rtp_idx_hi, rtp_sub, rtp_data, img_rd, img_addr,
      output rtp_done, rtp_err, img_rvalid, img_rdata);
   modport network_interface_module (output rtp_valid, rtp_len, rtp_idx_lo, rtp_idx_hi, rtp_sub, rtp_data, img_rd, img_addr,
      input rtp_done, rtp_err, img_rvalid, img_rdata);
endinterface : cipp_if

//--- cipp_dev.sv
`timescale 1ns/1ps
// Operation
// R1 - each channel averages samples, default one, max 80
// R2 - averaging count per channel, byte, 1 to 80
// R3 - averaging request: length 1, index 0x2402, sub 1-4
// R4 - every channel enabled after configuration
// R5 - disabled channel reads zero, never blinks
// R6 - eight words: data then status per channel
// R7 - host places words in input image by slot
// R8 - calibrated 4 mA reads 0, 20 mA full
// R9 - configurator records raw 4/20 mA readings as calibration
// R10 - host needs global interrupt enable before receiving data
// R11 - status bit 0 ORs bits 1,3,6,7
// R12 - offset request: index 0x2400, sub 1-4
// R13 - report mean of last N samples
// R14 - clear averaging on count change or disable
module cipp_dev #(
   parameter int AVG_MAX = cipp_pkg::AVG_MAX,
   parameter int BLINK_CYC = cipp_pkg::BLINK_CYC
) (
   input wire logic mclk,
   input wire logic reset,
   cipp_if.dev link,
   input wire logic smp_valid,
   output logic smp_ready,
   input wire logic [1:0] smp_ch,
   input wire logic [15:0] smp_raw,
   input wire logic unsigned_fmt,
   input wire logic [cipp_pkg::NCH*8-1:0] fault_in,
   output logic [cipp_pkg::NCH-1:0] fault_led
);
   import cipp_pkg::*;
   localparam int AW = $clog2(AVG_MAX + 1);
   localparam int HW = $clog2(NCH * AVG_MAX);
   typedef enum logic [2:0] {S_IDLE, S_AVG, S_WAIT1, S_CAL, S_WAIT2, S_OUT} cipp_st_t;

   function automatic logic sub_ok(input logic [7:0] s);
      return (s >= SUB_LO) && (s <= SUB_HI);
   endfunction : sub_ok

   cipp_st_t st_q;
   logic ready_q, neg_q, done_q, err_q, rv_q, blink_q;
   logic [1:0] pch_q;
   logic [15:0] rd_q;
   logic [NCH-1:0] en_q, led_q;
   logic signed [17:0] avg_q;
   logic signed [17:0] hist_q [NCH*AVG_MAX];
   logic [AW-1:0] wp_q [NCH];
   logic [AW-1:0] cnt_q [NCH];
   logic signed [23:0] sum_q [NCH];
   logic [7:0] avgn_q [NCH];
   logic signed [15:0] off_q [NCH];
   logic [15:0] max_q [NCH];
   logic [15:0] data_q [NCH];
   logic [7:0] stat_q [NCH];
   logic [31:0] bcnt_q;
   logic [39:0] dvd_q;
   logic [16:0] dvs_q;
   logic [17:0] rem_q;
   logic [5:0] dcnt_q;

   logic ok, acc, dstart;
   logic [1:0] rch;
   logic [NCH-1:0] clr;
   logic signed [17:0] ext, old;
   logic [HW-1:0] hidx;
   logic [39:0] da;
   logic [16:0] db, full;
   logic signed [18:0] dif, sp, maxv, res;
   logic [17:0] qm, t;

   // request decode
   always_comb begin
      rch = 2'(link.rtp_sub - SUB_LO);
      ok = 1'b0;
      if (link.rtp_valid && link.rtp_idx_hi == IDX_HI && sub_ok(link.rtp_sub)) begin // [R3] [R12]
         unique case (link.rtp_idx_lo)
            IDX_OFFSET: ok = (link.rtp_len == LEN_WORD); // [R12]
            IDX_MAXCNT: ok = (link.rtp_len == LEN_WORD);
            IDX_AVG: ok = (link.rtp_len == LEN_BYTE) && link.rtp_data[7:0] >= AVG_LO
               && link.rtp_data[7:0] <= AVG_HI; // [R2] [R3]
            IDX_ENABLE: ok = (link.rtp_len == LEN_BYTE);
            default: ok = 1'b0;
         endcase
      end
      for (int c = 0; c < NCH; c++) begin
         clr[c] = ok && rch == 2'(c) && ((link.rtp_idx_lo == IDX_AVG && link.rtp_data[7:0] != avgn_q[c])
            || (link.rtp_idx_lo == IDX_ENABLE && !link.rtp_data[0])); // [R14]
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         for (int c = 0; c < NCH; c++) begin
            off_q[c] <= 16'h0000;
            max_q[c] <= 16'h0000;
            avgn_q[c] <= AVG_RST; // [R1]
         end
         en_q <= '1; // [R4]
      end else if (ok) begin
         unique case (link.rtp_idx_lo)
            IDX_OFFSET: off_q[rch] <= link.rtp_data;
            IDX_MAXCNT: max_q[rch] <= link.rtp_data;
            IDX_AVG: avgn_q[rch] <= link.rtp_data[7:0]; // [R2]
            IDX_ENABLE: en_q[rch] <= link.rtp_data[0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         done_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         done_q <= link.rtp_valid;
         err_q <= link.rtp_valid && !ok;
      end
   end

   // sample intake; a disabled channel's samples are taken and dropped
   assign acc = smp_valid && ready_q && en_q[smp_ch]; // [R5]
   assign ext = unsigned_fmt ? {2'b00, smp_raw} : {{2{smp_raw[15]}}, smp_raw};
   assign hidx = HW'(32'(smp_ch) * AVG_MAX + 32'(wp_q[smp_ch]));
   assign old = hist_q[hidx];

   always_ff @(posedge mclk) begin
      if (acc) begin
         hist_q[hidx] <= ext;
      end
   end

   // running sum over a ring of the last N samples
   always_ff @(posedge mclk) begin
      for (int c = 0; c < NCH; c++) begin
         if (reset || clr[c]) begin // [R14]
            wp_q[c] <= '0;
            cnt_q[c] <= '0;
            sum_q[c] <= '0;
         end else if (acc && smp_ch == 2'(c)) begin
            if (cnt_q[c] == AW'(avgn_q[c])) begin
               sum_q[c] <= sum_q[c] + 24'(ext) - 24'(old); // [R13]
            end else begin
               sum_q[c] <= sum_q[c] + 24'(ext); // [R13]
               cnt_q[c] <= cnt_q[c] + 1'b1;
            end
            wp_q[c] <= (wp_q[c] + 1'b1 == AW'(avgn_q[c])) ? '0 : wp_q[c] + 1'b1; // [R1]
         end
      end
   end

   // calibration: (avg - offset) * full / (max - offset); max of zero means uncalibrated
   always_comb begin
      full = unsigned_fmt ? FULL_UNS : FULL_SGN;
      dif = 19'(avg_q) - 19'(off_q[pch_q]);
      maxv = unsigned_fmt ? {3'b000, max_q[pch_q]} : {{3{max_q[pch_q][15]}}, max_q[pch_q]};
      sp = maxv - 19'(off_q[pch_q]);
      if (max_q[pch_q] == 16'h0000 || sp <= 0) begin
         sp = 19'(full);
      end
      dstart = 1'b0;
      da = '0;
      db = 17'h00001;
      if (st_q == S_AVG) begin
         dstart = 1'b1;
         da = 40'(sum_q[pch_q] < 0 ? -sum_q[pch_q] : sum_q[pch_q]); // [R13]
         db = (cnt_q[pch_q] == '0) ? 17'h00001 : 17'(cnt_q[pch_q]);
      end else if (st_q == S_CAL) begin
         dstart = 1'b1;
         da = 40'(dif < 0 ? -dif : dif) * 40'(full); // [R8]
         db = sp[16:0];
      end
      qm = (|dvd_q[39:17]) ? 18'h1FFFF : dvd_q[17:0];
      res = neg_q ? -19'(qm) : 19'(qm);
      if (unsigned_fmt) begin
         res = (res < 0) ? '0 : (res > CLAMP_UNS_HI ? CLAMP_UNS_HI : res);
      end else begin
         res = (res < CLAMP_SGN_LO) ? CLAMP_SGN_LO : (res > CLAMP_SGN_HI ? CLAMP_SGN_HI : res);
      end
      t = {rem_q[16:0], dvd_q[39]};
   end

   // restoring divider, one quotient bit per cycle
   always_ff @(posedge mclk) begin
      if (reset) begin
         dcnt_q <= '0;
         dvd_q <= '0;
         dvs_q <= 17'h00001;
         rem_q <= '0;
      end else if (dstart) begin
         dcnt_q <= DIV_STEPS;
         dvd_q <= da;
         dvs_q <= db;
         rem_q <= '0;
      end else if (dcnt_q != '0) begin
         dcnt_q <= dcnt_q - 1'b1;
         if (t >= 18'(dvs_q)) begin
            rem_q <= t - 18'(dvs_q);
            dvd_q <= {dvd_q[38:0], 1'b1};
         end else begin
            rem_q <= t;
            dvd_q <= {dvd_q[38:0], 1'b0};
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         st_q <= S_IDLE;
         ready_q <= 1'b0;
         pch_q <= 2'b00;
         neg_q <= 1'b0;
         avg_q <= '0;
      end else begin
         unique case (st_q)
            S_IDLE: begin
               ready_q <= !acc;
               if (acc) begin
                  pch_q <= smp_ch;
                  st_q <= S_AVG;
               end
            end
            S_AVG: begin
               neg_q <= sum_q[pch_q] < 0;
               st_q <= S_WAIT1;
            end
            S_WAIT1: if (dcnt_q == '0) begin
               avg_q <= neg_q ? -dvd_q[17:0] : dvd_q[17:0]; // [R13]
               st_q <= S_CAL;
            end
            S_CAL: begin
               neg_q <= dif < 0;
               st_q <= S_WAIT2;
            end
            S_WAIT2: if (dcnt_q == '0) begin
               st_q <= S_OUT;
            end
            S_OUT: begin
               ready_q <= 1'b1;
               st_q <= S_IDLE;
            end
         endcase
      end
   end

   // process image words
   always_ff @(posedge mclk) begin
      for (int c = 0; c < NCH; c++) begin
         if (reset || !en_q[c]) begin
            data_q[c] <= 16'h0000; // [R5]
            stat_q[c] <= 8'h00; // [R5]
         end else begin
            if (st_q == S_WAIT2 && dcnt_q == '0 && pch_q == 2'(c)) begin
               data_q[c] <= res[15:0]; // [R8]
            end
            stat_q[c] <= {fault_in[c*8+1 +: 7], fault_in[c*8+ST_PDM] | fault_in[c*8+ST_OCE]
               | fault_in[c*8+ST_BWE] | fault_in[c*8+ST_ICE]}; // [R11]
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         rv_q <= 1'b0;
         rd_q <= 16'h0000;
      end else begin
         rv_q <= link.img_rd;
         rd_q <= link.img_addr[0] ? {8'h00, stat_q[link.img_addr[2:1]]} : data_q[link.img_addr[2:1]]; // [R6]
      end
   end

   // fault indicator blinks while the global flag is up
   always_ff @(posedge mclk) begin
      if (reset) begin
         bcnt_q <= '0;
         blink_q <= 1'b0;
         led_q <= '0;
      end else begin
         bcnt_q <= (bcnt_q >= 32'(BLINK_CYC - 1)) ? '0 : bcnt_q + 1'b1;
         if (bcnt_q >= 32'(BLINK_CYC - 1)) begin
            blink_q <= !blink_q;
         end
         for (int c = 0; c < NCH; c++) begin
            led_q[c] <= en_q[c] && stat_q[c][ST_GS] && blink_q; // [R5]
         end
      end
   end

   assign smp_ready = ready_q;
   assign fault_led = led_q;
   assign link.rtp_done = done_q;
   assign link.rtp_err = err_q;
   assign link.img_rvalid = rv_q;
   assign link.img_rdata = rd_q;
endmodule : cipp_dev

//--- cipp_host.sv
`timescale 1ns/1ps
module cipp_host (
   input wire logic mclk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   cipp_if.network_interface_module link
);
   import cipp_pkg::*;

   function automatic logic mapped(input logic [7:0] a);
      return a <= A_IMASK || (a >= A_IMG && a < A_IMG + 8'(IMG_WORDS * 4) && a[1:0] == 2'b00);
   endfunction : mapped

   logic rdy_q, err_q, gie_q, busy_q, rerr_q, v_q, rd_q, pend_q, irq_q;
   logic [31:0] prd_q;
   logic [15:0] base_q, data_q;
   logic [31:0] cmd_q;
   logic [IRQ_W-1:0] ist_q, imask_q, iset;
   logic [2:0] sp_q;
   logic [15:0] img_q [IMG_WORDS];
   logic acc_ph, wr_now, bad;
   logic [31:0] rdv;

   assign acc_ph = psel && penable && !rdy_q;
   assign wr_now = psel && penable && rdy_q && pwrite && !err_q;

   always_comb begin
      bad = !mapped(paddr) || paddr[1:0] != 2'b00;
      if (pwrite && paddr == A_BASE) begin
         bad = pwdata[15:0] < IMG_FIRST || pwdata[15:0] > IMG_LAST - 16'(IMG_WORDS - 1); // [R7]
      end
      if (pwrite && paddr == A_CMD && busy_q) begin
         bad = 1'b1;
      end
      rdv = 32'h00000000;
      unique case (paddr)
         A_CTRL: rdv = {31'h0, gie_q};
         A_BASE: rdv = {16'h0000, base_q};
         A_CMD: rdv = cmd_q;
         A_DATA: rdv = {16'h0000, data_q};
         A_STAT: rdv = {30'h0, rerr_q, busy_q};
         A_ISTAT: rdv = 32'(ist_q);
         A_IMASK: rdv = 32'(imask_q);
         default: if (paddr >= A_IMG) begin
            rdv = {16'h0000, img_q[3'(paddr[4:2])]};
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         rdy_q <= 1'b0;
         err_q <= 1'b0;
         prd_q <= '0;
      end else begin
         rdy_q <= acc_ph;
         err_q <= acc_ph && bad;
         prd_q <= (acc_ph && !pwrite && !bad) ? rdv : '0;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         gie_q <= 1'b0;
         base_q <= IMG_FIRST;
         data_q <= 16'h0000;
         imask_q <= '0;
      end else if (wr_now) begin
         if (paddr == A_CTRL) gie_q <= pwdata[0]; // [R10]
         if (paddr == A_BASE) base_q <= pwdata[15:0]; // [R7]
         if (paddr == A_DATA) data_q <= pwdata[15:0]; // [R9]
         if (paddr == A_IMASK) imask_q <= pwdata[IRQ_W-1:0];
      end
   end

   // parameter requests: one in flight at a time
   always_ff @(posedge mclk) begin
      if (reset) begin
         cmd_q <= '0;
         v_q <= 1'b0;
         busy_q <= 1'b0;
         rerr_q <= 1'b0;
      end else begin
         v_q <= wr_now && paddr == A_CMD;
         if (wr_now && paddr == A_CMD) begin
            cmd_q <= pwdata; // [R3] [R12]
            busy_q <= 1'b1;
         end else if (link.rtp_done) begin
            busy_q <= 1'b0;
            rerr_q <= link.rtp_err;
         end
      end
   end

   // image scan, only while the global enable is set
   always_ff @(posedge mclk) begin
      if (reset) begin
         rd_q <= 1'b0;
         pend_q <= 1'b0;
         sp_q <= 3'h0;
         for (int k = 0; k < IMG_WORDS; k++) img_q[k] <= 16'h0000;
      end else begin
         rd_q <= gie_q && !pend_q; // [R10]
         if (gie_q && !pend_q) begin
            pend_q <= 1'b1;
         end else if (link.img_rvalid) begin
            img_q[sp_q] <= link.img_rdata; // [R6]
            sp_q <= sp_q + 1'b1;
            pend_q <= 1'b0;
         end
      end
   end

   always_comb begin
      iset = '0;
      iset[IRQ_RTP] = link.rtp_done;
      iset[IRQ_SCAN] = link.img_rvalid && sp_q == 3'(IMG_WORDS - 1);
      iset[IRQ_GS] = link.img_rvalid && sp_q[0] && link.img_rdata[ST_GS];
   end

   // set beats a same-cycle write-one clear
   always_ff @(posedge mclk) begin
      if (reset) begin
         ist_q <= '0;
         irq_q <= 1'b0;
      end else begin
         ist_q <= (ist_q & ~((wr_now && paddr == A_ISTAT) ? pwdata[IRQ_W-1:0] : '0)) | iset;
         irq_q <= |(ist_q & imask_q);
      end
   end

   assign prdata = prd_q;
   assign pready = rdy_q;
   assign pslverr = err_q;
   assign irq = irq_q;
   assign link.rtp_valid = v_q;
   assign link.rtp_idx_lo = cmd_q[7:0];
   assign link.rtp_idx_hi = cmd_q[15:8];
   assign link.rtp_sub = cmd_q[23:16];
   assign link.rtp_len = cmd_q[31:24];
   assign link.rtp_data = data_q;
   assign link.img_rd = rd_q;
   assign link.img_addr = sp_q;
endmodule : cipp_host

//--- cipp_assertions.sv
`timescale 1ns/1ps
module cipp_assertions (
   input wire logic mclk,
   input wire logic reset,
   input wire logic rtp_valid,
   input wire logic [7:0] rtp_len,
   input wire logic [7:0] rtp_idx_lo,
   input wire logic [7:0] rtp_idx_hi,
   input wire logic [7:0] rtp_sub,
   input wire logic [15:0] rtp_data,
   input wire logic rtp_done,
   input wire logic rtp_err,
   input wire logic img_rd,
   input wire logic [2:0] img_addr,
   input wire logic img_rvalid,
   input wire logic [15:0] img_rdata
);
   import cipp_pkg::*;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   wire sub_ok = rtp_sub >= SUB_LO && rtp_sub <= SUB_HI;
   wire hdr_ok = rtp_valid && rtp_idx_hi == IDX_HI && sub_ok;
   sequence s_avg_req;
      hdr_ok && rtp_idx_lo == IDX_AVG && rtp_len == LEN_BYTE;
   endsequence
   sequence s_refused;
      rtp_done && rtp_err;
   endsequence
   property p_done;
      rtp_valid |=> rtp_done;
   endproperty
   a_done: assert property (p_done) else $error("request not answered");
   property p_no_spurious;
      rtp_done |-> $past(rtp_valid);
   endproperty
   a_no_spurious: assert property (p_no_spurious) else $error("answer without request");
   property p_bad_hi;
      rtp_valid && rtp_idx_hi != IDX_HI |=> s_refused;
   endproperty
   a_bad_hi: assert property (p_bad_hi) else $error("bad index high accepted");
   property p_bad_sub;
      rtp_valid && !sub_ok |=> s_refused;
   endproperty
   a_bad_sub: assert property (p_bad_sub) else $error("bad channel accepted");
   property p_avg_len;
      hdr_ok && rtp_idx_lo == IDX_AVG && rtp_len != LEN_BYTE |=> s_refused;
   endproperty
   a_avg_len: assert property (p_avg_len) else $error("averaging length accepted");
   property p_avg_range;
      s_avg_req ##0 (rtp_data[7:0] < AVG_LO || rtp_data[7:0] > AVG_HI) |=> s_refused;
   endproperty
   a_avg_range: assert property (p_avg_range) else $error("averaging count out of range accepted");
   property p_avg_ok;
      s_avg_req ##0 (rtp_data[7:0] >= AVG_LO && rtp_data[7:0] <= AVG_HI) |=> rtp_done && !rtp_err;
   endproperty
   a_avg_ok: assert property (p_avg_ok) else $error("valid averaging count refused");
   property p_off_len;
      hdr_ok && rtp_idx_lo == IDX_OFFSET && rtp_len != LEN_WORD |=> s_refused;
   endproperty
   a_off_len: assert property (p_off_len) else $error("offset length accepted");
   property p_img;
      img_rd |=> img_rvalid;
   endproperty
   a_img: assert property (p_img) else $error("image read not answered");
   property p_gs;
      img_rvalid && $past(img_addr[0]) |-> img_rdata[15:8] == 8'h00 &&
         img_rdata[0] == (img_rdata[1] | img_rdata[3] | img_rdata[6] | img_rdata[7]);
   endproperty
   a_gs: assert property (p_gs) else $error("global error flag wrong");
endmodule : cipp_assertions

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import cipp_pkg::*;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready, pslverr, irq, perr, smp_ready;
   logic smp_valid = 1'b0;
   logic unsigned_fmt = 1'b0;
   logic [1:0] smp_ch = 2'h0;
   logic [15:0] smp_raw = 16'h0;
   logic [31:0] fault_in = 32'h0;
   logic [3:0] fault_led;
   logic mask_on = 1'b1;
   int failures = 0;
   int n_checks = 0;
   always #5 mclk = ~mclk;
   cipp_if link ();
   // short blink period keeps the toggle visible in a few cycles
   cipp_dev #(.BLINK_CYC(4)) cipp_dev_i (.mclk(mclk), .reset(reset), .link(link), .smp_valid(smp_valid),
      .smp_ready(smp_ready), .smp_ch(smp_ch), .smp_raw(smp_raw), .unsigned_fmt(unsigned_fmt),
      .fault_in(fault_in), .fault_led(fault_led));
   cipp_host cipp_host_i (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .link(link));
   cipp_assertions cipp_assertions_i (.mclk(mclk), .reset(reset), .rtp_valid(link.rtp_valid),
      .rtp_len(link.rtp_len), .rtp_idx_lo(link.rtp_idx_lo), .rtp_idx_hi(link.rtp_idx_hi),
      .rtp_sub(link.rtp_sub), .rtp_data(link.rtp_data), .rtp_done(link.rtp_done), .rtp_err(link.rtp_err),
      .img_rd(link.img_rd), .img_addr(link.img_addr), .img_rvalid(link.img_rvalid),
      .img_rdata(link.img_rdata));
   task automatic summarize();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   task automatic tmo(input int i, input int lim);
      if (i >= lim) begin
         failures++;
         summarize();
      end
   endtask : tmo
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge mclk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      tmo(i, 50);
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask : apb
   task automatic runtime_parameter_request(input logic [31:0] cmd, input logic [15:0] d, input logic exp_err);
      int i;
      apb(1'b1, A_DATA, {16'h0000, d});
      apb(1'b1, A_CMD, cmd);
      i = 0;
      do begin
         apb(1'b0, A_ISTAT, 32'h0);
         i++;
      end while (rd[0] !== 1'b1 && i < 20);
      tmo(i, 20);
      chk(irq, mask_on);
      apb(1'b1, A_ISTAT, 32'h1);
      apb(1'b0, A_STAT, 32'h0);
      chk(rd[1:0], {exp_err, 1'b0});
      chk(irq, 1'b0);
      apb(1'b0, A_CMD, 32'h0);
      chk(rd, cmd);
   endtask : runtime_parameter_request
   task automatic smp(input logic [1:0] c, input logic [15:0] v);
      int i;
      smp_valid <= 1'b1;
      smp_ch <= c;
      smp_raw <= v;
      @(posedge mclk);
      smp_valid <= 1'b0;
      i = 0;
      do begin
         @(posedge mclk);
         i++;
      end while (smp_ready !== 1'b1 && i < 300);
      tmo(i, 300);
   endtask : smp
   // two passes so the image holds words sampled after the last change
   task automatic scan();
      int i;
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, A_ISTAT, 32'h2);
         i = 0;
         do begin
            apb(1'b0, A_ISTAT, 32'h0);
            i++;
         end while (rd[1] !== 1'b1 && i < 40);
         tmo(i, 40);
      end
   endtask : scan
   task automatic img(input int k, input logic [15:0] e);
      apb(1'b0, 8'(A_IMG + 4 * k), 32'h0);
      chk(rd & 32'h0000FFFF, {16'h0000, e});
   endtask : img
   task automatic blink(output int n);
      logic l;
      n = 0;
      l = fault_led[3];
      repeat (24) begin
         @(posedge mclk);
         if (fault_led[3] !== l)
            n++;
         l = fault_led[3];
      end
   endtask : blink
   function automatic logic [15:0] cal(input int m, input int off, input int mx);
      int v;
      if (mx == 0)
         mx = 32000;
      v = (m - off) * 32000 / (mx - off);
      if (v < -767)
         v = -767;
      if (v > 32767)
         v = 32767;
      return 16'(v);
   endfunction : cal
   function automatic logic [7:0] stat(input logic [7:0] f);
      return {f[7:1], f[1] | f[3] | f[6] | f[7]};
   endfunction : stat
   initial begin
      logic [15:0] s[$];
      logic [15:0] v;
      logic [7:0] f;
      int sum;
      logic [7:0] cv[4] = '{8'h00, 8'h01, 8'h50, 8'h51};
      logic [31:0] bad[8] = '{32'h01012502, 32'h01002402, 32'h01052402, 32'h01012404,
         32'h01012400, 32'h02012402, 32'h02012403, 32'h01012401};
      void'($urandom(82547));
      repeat (6) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      apb(1'b0, A_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, A_BASE, 32'h0);
      chk(rd, 32'h0000B150);
      apb(1'b0, A_IMASK, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h1C, 32'h0);
      chk(perr, 1'b1);
      apb(1'b1, A_BASE, 32'h0000C148);
      chk(perr, 1'b0);
      apb(1'b1, A_BASE, 32'h0000C149);
      chk(perr, 1'b1);
      apb(1'b0, A_BASE, 32'h0);
      chk(rd, 32'h0000C148);
      apb(1'b1, A_IMASK, 32'h1);
      apb(1'b1, A_CTRL, 32'h1);
      for (int t = 0; t < 5; t++) begin
         v = (t == 0) ? 16'h8000 : 16'($urandom_range(34000) - 1200);
         smp(2'h0, v);
         scan();
         img(0, cal(int'(signed'(v)), 0, 0));
      end
      foreach (bad[j])
         runtime_parameter_request(bad[j], 16'h0001, 1'b1);
      for (int t = 0; t < 10; t++) begin
         v = (t < 4) ? {8'h00, cv[t]} : 16'($urandom_range(120));
         runtime_parameter_request({LEN_BYTE, 8'($urandom_range(4, 1)), IDX_HI, IDX_AVG}, v, !(v >= 1 && v <= 80));
      end
      runtime_parameter_request({LEN_BYTE, 8'h02, IDX_HI, IDX_AVG}, 16'h0004, 1'b0);
      for (int t = 0; t < 6; t++) begin
         // multiples of 12 keep every mean of up to four samples exact
         v = 16'(12 * $urandom_range(600));
         s.push_back(v);
         if (s.size() > 4)
            void'(s.pop_front());
         sum = 0;
         foreach (s[j])
            sum += s[j];
         smp(2'h1, v);
         scan();
         img(2, 16'(sum / s.size()));
      end
      runtime_parameter_request({LEN_BYTE, 8'h02, IDX_HI, IDX_AVG}, 16'h0003, 1'b0);
      smp(2'h1, 16'h0030);
      scan();
      img(2, 16'h0030);
      runtime_parameter_request({LEN_BYTE, 8'h03, IDX_HI, IDX_AVG}, 16'h0001, 1'b0);
      runtime_parameter_request({LEN_WORD, 8'h03, IDX_HI, IDX_OFFSET}, 16'h0040, 1'b0);
      runtime_parameter_request({LEN_WORD, 8'h03, IDX_HI, IDX_MAXCNT}, 16'h7C00, 1'b0);
      smp(2'h2, 16'h0040);
      scan();
      img(4, 16'h0000);
      smp(2'h2, 16'h7C00);
      scan();
      img(4, 16'h7D00);
      // unsigned format: full scale 64000, results below offset clamp to zero
      unsigned_fmt <= 1'b1;
      smp(2'h2, 16'h7C00);
      scan();
      img(4, 16'hFA00);
      smp(2'h2, 16'h0010);
      scan();
      img(4, 16'h0000);
      unsigned_fmt <= 1'b0;
      for (int t = 0; t < 4; t++) begin
         f = (t == 0) ? 8'h04 : 8'($urandom_range(255));
         fault_in[31:24] <= f;
         scan();
         img(7, {8'h00, stat(f)});
      end
      fault_in[31:24] <= 8'h80;
      blink(sum);
      chk(sum > 0, 1'b1);
      scan();
      apb(1'b0, A_ISTAT, 32'h0);
      chk(rd[2], 1'b1);
      mask_on = 1'b0;
      apb(1'b1, A_IMASK, 32'h0);
      runtime_parameter_request({LEN_BYTE, 8'h04, IDX_HI, IDX_ENABLE}, 16'h0000, 1'b0);
      smp(2'h3, 16'h1234);
      scan();
      img(6, 16'h0000);
      img(7, 16'h0000);
      blink(sum);
      chk({fault_led[3], sum[7:0]}, 32'h0);
      runtime_parameter_request({LEN_BYTE, 8'h04, IDX_HI, IDX_ENABLE}, 16'h0001, 1'b0);
      scan();
      img(7, {8'h00, stat(8'h80)});
      summarize();
   end
endmodule : tb_top
